// *** pds_pkg.sv ***
// Constants and carrier types for the pixel digital shift datapath.
// Assumes one pixel clock domain and settings driven by local logic.
// What this block does
// RULE_01: Accept 12-bit unsigned converter tap samples.
// RULE_02: 12-bit depth, no shift: pass sample.
// RULE_03: 12-bit, shift 1: bits 10..0, one zero.
// RULE_04: 12-bit, shift 2: bits 9..0, two zeros.
// RULE_05: 12-bit, shift 3: bits 8..0, three zeros.
// RULE_06: 12-bit, shift 4: bits 7..0, four zeros.
// RULE_07: 8-bit, no shift: output bits 11..4.
// RULE_08: 8-bit, shift 1: output bits 10..3.
// RULE_09: 8-bit, shift 2: output bits 9..2.
// RULE_10: 8-bit, shift 3: output bits 8..1.
// RULE_11: 8-bit, shift 4: output bits 7..0.
// RULE_12: Shift 1 with bit 11 set saturates.
// RULE_13: Shifts 2-4 saturate on dropped high bits.
// RULE_14: Shift code 0 off, 1-4 select shift.
// RULE_15: Software: 12-bit shift only below thresholds.
// RULE_16: Software: 8-bit shift only below thresholds.
// RULE_17: Settings sampled once per frame.
package pds_pkg;

    // Widths
    localparam int PDS_SMP_W = 12;
    localparam int PDS_OUT8_W = 8;
    localparam int PDS_SHIFT_W = 3;
    localparam int PDS_OUT8_LSB = 4;

    // Shift setting codes
    localparam logic [2:0] PDS_SHIFT_OFF = 3'h0;
    localparam logic [2:0] PDS_SHIFT_1 = 3'h1;
    localparam logic [2:0] PDS_SHIFT_2 = 3'h2;
    localparam logic [2:0] PDS_SHIFT_3 = 3'h3;
    localparam logic [2:0] PDS_SHIFT_4 = 3'h4;

    // Saturated output words
    localparam logic [11:0] PDS_SAT12 = 12'hFFF;
    localparam logic [7:0] PDS_SAT8 = 8'hFF;

    // Values after reset
    localparam logic [11:0] PDS_RST_DATA = 12'h000;
    localparam logic [2:0] PDS_RST_SHIFT = 3'h0;
    localparam logic PDS_RST_DEPTH8 = 1'b0;
    localparam logic PDS_RST_VALID = 1'b0;
    localparam logic PDS_RST_SAT = 1'b0;

    // Output settings for one frame
    typedef struct packed {
        logic depth8;
        logic [2:0] shift;
    } pds_cfg_type;

    // One pixel on the stream
    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } pds_pix_type;

    localparam pds_cfg_type PDS_RST_CFG = '{depth8: PDS_RST_DEPTH8, shift: PDS_RST_SHIFT};
    localparam pds_pix_type PDS_RST_PIX = '{valid: PDS_RST_VALID, data: PDS_RST_DATA};

endpackage

// *** pds_top.sv ***
// Pixel digital shift datapath: selects the transmitted bit window of
// each converter sample and saturates when dropped high bits are set.
// Assumes samples, frame start and settings come from logic on clk_sys.
module pds_top
    import pds_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Frame control and settings
    input wire logic frame_start,
    input wire logic [2:0] shift_sel,
    input wire logic depth8_sel,
    // Sample input
    input wire logic smp_valid,
    input wire logic [11:0] smp_data,
    // Pixel output
    output logic pix_valid,
    output logic [11:0] pix_data,
    output logic pix_depth8,
    output logic pix_sat
);

    // Frame settings and output registers
    pds_cfg_type cfg_ff;
    pds_cfg_type nxt_cfg;
    pds_cfg_type eff_cfg;
    pds_pix_type pix_ff;
    pds_pix_type nxt_pix;
    logic depth8_ff;
    logic nxt_depth8;
    logic sat_ff;
    logic nxt_sat;

    // Datapath intermediates
    logic [11:0] win12;
    logic over;
    logic [7:0] win8;

    // Settings in force for the current sample
    always_comb begin
        eff_cfg = cfg_ff;
        if (frame_start) begin
            eff_cfg.depth8 = depth8_sel;
            eff_cfg.shift = shift_sel; // [RULE_17]
        end
    end

    // Next frame settings
    always_comb begin
        nxt_cfg = cfg_ff;
        if (frame_start) begin
            nxt_cfg = eff_cfg; // [RULE_17]
        end
    end

    // Frame settings register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_ff <= PDS_RST_CFG;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Shifted 12-bit window and overflow of dropped high bits
    always_comb begin
        win12 = smp_data; // [RULE_01]
        over = 1'b0;
        case (eff_cfg.shift) // [RULE_14]
            PDS_SHIFT_OFF: begin
                win12 = smp_data; // [RULE_02]
                over = 1'b0;
            end
            PDS_SHIFT_1: begin
                win12 = {smp_data[10:0], 1'b0}; // [RULE_03]
                over = smp_data[11]; // [RULE_12]
            end
            PDS_SHIFT_2: begin
                win12 = {smp_data[9:0], 2'h0}; // [RULE_04]
                over = |smp_data[11:10]; // [RULE_13]
            end
            PDS_SHIFT_3: begin
                win12 = {smp_data[8:0], 3'h0}; // [RULE_05]
                over = |smp_data[11:9]; // [RULE_13]
            end
            PDS_SHIFT_4: begin
                win12 = {smp_data[7:0], 4'h0}; // [RULE_06]
                over = |smp_data[11:8]; // [RULE_13]
            end
            default: begin
                win12 = smp_data; // Unused codes act as no shift
                over = 1'b0;
            end
        endcase
    end

    // Eight-bit window is the top byte of the shifted word
    assign win8 = win12[11:PDS_OUT8_LSB]; // [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11]

    // Next output pixel
    always_comb begin
        nxt_pix.valid = smp_valid;
        nxt_pix.data = pix_ff.data;
        nxt_depth8 = depth8_ff;
        nxt_sat = sat_ff;
        if (smp_valid) begin
            nxt_depth8 = eff_cfg.depth8;
            nxt_sat = over;
            if (eff_cfg.depth8) begin
                nxt_pix.data = {4'h0, over ? PDS_SAT8 : win8}; // [RULE_12] [RULE_13]
            end else begin
                nxt_pix.data = over ? PDS_SAT12 : win12; // [RULE_12] [RULE_13]
            end
        end
    end

    // Output registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pix_ff <= PDS_RST_PIX;
            depth8_ff <= PDS_RST_DEPTH8;
            sat_ff <= PDS_RST_SAT;
        end else begin
            pix_ff <= nxt_pix;
            depth8_ff <= nxt_depth8;
            sat_ff <= nxt_sat;
        end
    end

    // Outputs straight from flip-flops
    assign pix_valid = pix_ff.valid;
    assign pix_data = pix_ff.data;
    assign pix_depth8 = depth8_ff;
    assign pix_sat = sat_ff;

    // Helper copies of the previous sample for the checks
    logic [11:0] chk_smp_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chk_smp_ff <= PDS_RST_DATA;
        end else begin
            chk_smp_ff <= smp_data;
        end
    end

    // Reference overflow for the checks, from a shift rather than the case,
    // so that a wrong case arm cannot hide behind its own result
    logic chk_over;
    always_comb begin
        chk_over = 1'b0;
        if ((eff_cfg.shift != PDS_SHIFT_OFF) && (eff_cfg.shift <= PDS_SHIFT_4)) begin
            chk_over = |(smp_data >> (PDS_SMP_W - int'(eff_cfg.shift)));
        end
    end

    // Settings in force for the previous sample, for the checks
    logic chk_d8_ff;
    logic [2:0] chk_sh_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chk_d8_ff <= PDS_RST_DEPTH8;
            chk_sh_ff <= PDS_RST_SHIFT;
        end else begin
            chk_d8_ff <= eff_cfg.depth8;
            chk_sh_ff <= eff_cfg.shift;
        end
    end

    // A sample taken with given depth and shift
    sequence s_take(logic d8, logic [2:0] sh);
        smp_valid && (eff_cfg.depth8 == d8) && (eff_cfg.shift == sh);
    endsequence

    // Sample taken with no dropped high bits
    sequence s_take_ok(logic d8, logic [2:0] sh);
        s_take(d8, sh) && !over;
    endsequence

    // Output word forced to all ones at the depth of its sample
    sequence s_sat_word;
        pix_sat && (pix_data == (chk_d8_ff ? {4'h0, PDS_SAT8} : PDS_SAT12));
    endsequence

    // Latency, settings, per-mode window, saturation and no-shift checks
    AST_VALID_LAT: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_01]
        smp_valid |=> pix_valid)
        else $error("sample not delivered one cycle later");

    AST_CFG_LATCH: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_17]
        frame_start |=> (cfg_ff.shift == $past(shift_sel))
            && (cfg_ff.depth8 == $past(depth8_sel)))
        else $error("settings not latched at frame start");

    AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_17]
        !frame_start |=> $stable(cfg_ff))
        else $error("settings changed inside frame");

    AST_P12_S0: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
        s_take(1'b0, PDS_SHIFT_OFF) |=> pix_data == chk_smp_ff)
        else $error("12-bit no shift output wrong");

    AST_P12_S1: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
        s_take_ok(1'b0, PDS_SHIFT_1) |=> pix_data == {chk_smp_ff[10:0], 1'b0})
        else $error("12-bit shift 1 output wrong");

    AST_P12_S2: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
        s_take_ok(1'b0, PDS_SHIFT_2) |=> pix_data == {chk_smp_ff[9:0], 2'h0})
        else $error("12-bit shift 2 output wrong");

    AST_P12_S3: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
        s_take_ok(1'b0, PDS_SHIFT_3) |=> pix_data == {chk_smp_ff[8:0], 3'h0})
        else $error("12-bit shift 3 output wrong");

    AST_P12_S4: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
        s_take_ok(1'b0, PDS_SHIFT_4) |=> pix_data == {chk_smp_ff[7:0], 4'h0})
        else $error("12-bit shift 4 output wrong");

    AST_P8_S0: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07]
        s_take(1'b1, PDS_SHIFT_OFF) |=> pix_data == {4'h0, chk_smp_ff[11:4]})
        else $error("8-bit no shift output wrong");

    AST_P8_S1: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_08]
        s_take_ok(1'b1, PDS_SHIFT_1) |=> pix_data == {4'h0, chk_smp_ff[10:3]})
        else $error("8-bit shift 1 output wrong");

    AST_P8_S2: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
        s_take_ok(1'b1, PDS_SHIFT_2) |=> pix_data == {4'h0, chk_smp_ff[9:2]})
        else $error("8-bit shift 2 output wrong");

    AST_P8_S3: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_10]
        s_take_ok(1'b1, PDS_SHIFT_3) |=> pix_data == {4'h0, chk_smp_ff[8:1]})
        else $error("8-bit shift 3 output wrong");

    AST_P8_S4: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_11]
        s_take_ok(1'b1, PDS_SHIFT_4) |=> pix_data == {4'h0, chk_smp_ff[7:0]})
        else $error("8-bit shift 4 output wrong");

    AST_SAT_S1: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_12]
        (smp_valid && eff_cfg.shift == PDS_SHIFT_1 && smp_data[11]) |=>
            pix_sat && (pix_data == (pix_depth8 ? {4'h0, PDS_SAT8} : PDS_SAT12)))
        else $error("shift 1 did not saturate");

    AST_SAT_HI: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
        (smp_valid && eff_cfg.shift == PDS_SHIFT_2 && (|smp_data[11:10])) |=>
            pix_sat && (pix_data == (pix_depth8 ? {4'h0, PDS_SAT8} : PDS_SAT12)))
        else $error("shift 2 did not saturate");

    AST_SAT_S4: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
        (smp_valid && eff_cfg.shift == PDS_SHIFT_4 && (|smp_data[11:8])) |=>
            pix_sat && pix_data[7:0] == PDS_SAT8)
        else $error("shift 4 did not saturate");

    AST_NO_SHIFT_NO_SAT: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
        s_take(eff_cfg.depth8, PDS_SHIFT_OFF) |=> !pix_sat)
        else $error("saturation with shift disabled");

    AST_SAT_S3: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
        (smp_valid && eff_cfg.shift == PDS_SHIFT_3 && (|smp_data[11:9])) |=> s_sat_word)
        else $error("shift 3 did not saturate");

    AST_NO_SHIFT_HI: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
        (smp_valid && !eff_cfg.depth8 && (eff_cfg.shift > PDS_SHIFT_4)) |=>
            (pix_data == chk_smp_ff) && !pix_sat)
        else $error("unused shift code did not act as no shift");

    AST_CFG_SAME: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_17]
        (frame_start && smp_valid) |=> (pix_depth8 == $past(depth8_sel)))
        else $error("new settings not used by the frame start sample");

    // Checks against the independent reference, then upper-bit, depth flag and saturation word checks
    AST_SAT_REF: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_12] [RULE_13]
        (smp_valid && chk_over) |=> s_sat_word)
        else $error("dropped high bits did not saturate");

    AST_NOSAT_REF: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
        (smp_valid && !chk_over) |=> !pix_sat)
        else $error("saturation without dropped high bits");

    AST_P12_REF: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02] [RULE_06]
        (smp_valid && !eff_cfg.depth8 && !chk_over && (eff_cfg.shift <= PDS_SHIFT_4)) |=>
            (pix_data == (chk_smp_ff << chk_sh_ff)))
        else $error("12-bit window differs from reference");

    AST_P8_REF: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07] [RULE_11]
        (smp_valid && eff_cfg.depth8 && !chk_over && (eff_cfg.shift <= PDS_SHIFT_4)) |=>
            (pix_data[7:0] == 8'((chk_smp_ff << chk_sh_ff) >> PDS_OUT8_LSB)))
        else $error("8-bit window differs from reference");

    AST_P8_HIGH_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07]
        (smp_valid && eff_cfg.depth8) |=> (pix_data[11:8] == 4'h0))
        else $error("8-bit word has upper bits set");

    AST_DEPTH_OUT: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_17]
        smp_valid |=> (pix_depth8 == chk_d8_ff))
        else $error("depth flag does not match sample");

    AST_SAT_FLAG_WORD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_12]
        (pix_valid && pix_sat) |-> (pix_data == (pix_depth8 ? {4'h0, PDS_SAT8} : PDS_SAT12)))
        else $error("saturation flag without all ones word");

    // Idle cycles leave the pixel word alone
    AST_IDLE_LOW: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_01]
        !smp_valid |=> !pix_valid)
        else $error("pixel valid without sample");

    AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_01]
        !smp_valid |=> ($stable(pix_data) && $stable(pix_sat) && $stable(pix_depth8)))
        else $error("pixel word changed without sample");

endmodule

// *** pds_tap_model.sv ***
// Converter tap model that feeds samples into the shift datapath.
// Assumes the bench posts each request between a rising and a falling edge.
module pds_tap_model
    import pds_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Request from the bench
    input wire logic go,
    input wire logic [11:0] val,
    // Tap output
    output logic smp_valid,
    output logic [11:0] smp_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pattern, inverted every cycle so a stale word never matches
    logic [11:0] idle_pat = 12'hA5A;

    // Launch on the falling edge
    always @(negedge clk_sys) begin
        idle_pat <= ~idle_pat;
        smp_valid <= go;
        smp_data <= go ? val : idle_pat;
    end
endmodule

// *** pixel_digital_shift_tb_top.sv ***
// Self-checking bench for the pixel digital shift datapath.
// Assumes pds_top and the tap model on one 100 MHz clock.
module pixel_digital_shift_tb_top
    import pds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic frame_start = 1'b0;
    logic [2:0] shift_sel = 3'h0;
    logic depth8_sel = 1'b0;
    logic go = 1'b0;
    logic [11:0] val = 12'h000;
    logic smp_valid, pix_valid, pix_depth8, pix_sat;
    logic [11:0] smp_data, pix_data;
    logic cur_d8 = 1'b0;
    logic [2:0] cur_sh = 3'h0;
    logic [12:0] held = 13'h0000;
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'hCB64AD2D;

    // Clock generator
    always #5 clk_sys = ~clk_sys;

    pds_tap_model tap (.clk_sys(clk_sys), .go(go), .val(val), .smp_valid(smp_valid),
        .smp_data(smp_data));

    pds_top dut (.clk_sys(clk_sys), .rst(rst), .frame_start(frame_start),
        .shift_sel(shift_sel), .depth8_sel(depth8_sel), .smp_valid(smp_valid),
        .smp_data(smp_data), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_depth8(pix_depth8), .pix_sat(pix_sat));

    // Expected saturation flag and output word
    function automatic logic [12:0] exp_pix(input logic d8, input logic [2:0] sh,
                                            input logic [11:0] x);
        logic [2:0] s;
        logic sat;
        s = (sh > 3'h4) ? 3'h0 : sh;
        sat = (s != 3'h0) && ((x >> (12 - s)) != 12'h000);
        if (d8) return {sat, sat ? 12'h0FF : ((x >> (4 - s)) & 12'h0FF)};
        return {sat, sat ? 12'hFFF : (x << s)};
    endfunction

    // Verdict and end of run
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One comparison
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One cycle: optional frame start, optional sample, then check the pixel
    task automatic cyc(input logic fs, input logic v, input logic [11:0] x,
                       input logic [2:0] ns, input logic nd);
        logic [12:0] e;
        go = v;
        val = x;
        @(negedge clk_sys);
        frame_start <= fs;
        shift_sel <= ns;
        depth8_sel <= nd;
        if (fs) begin
            cur_sh = ns;
            cur_d8 = nd;
        end
        e = exp_pix(cur_d8, cur_sh, x);
        @(posedge clk_sys);
        #1;
        check({12'h000, pix_valid}, {12'h000, v});
        if (v) begin
            check({1'b0, pix_data}, {1'b0, e[11:0]});
            check({1'b0, pix_data}, {1'b0, e[11:0]});
            check({1'b0, pix_data}, {1'b0, e[11:0]});
            check({12'h000, pix_sat}, {12'h000, e[12]});
            check({12'h000, pix_depth8}, {12'h000, cur_d8});
            held = e;
        end else begin
            check({pix_sat, pix_data}, held);
        end
    endtask

    // Reset check shared by start and mid-run reset
    task automatic check_reset();
        check({pix_valid, pix_data}, PDS_RST_PIX);
        check({11'h000, pix_sat, pix_depth8}, 13'h0000);
    endtask

    // Watchdog
    initial begin
        #50us;
        err_count++;
        conclude();
    end

    // Main sequence
    initial begin
        int r;
        int s;
        logic [11:0] x;
        repeat (20) @(posedge clk_sys);
        #1;
        check_reset();
        @(negedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        // Every depth and shift code, with corner and random samples
        for (int f = 0; f < 16; f++) begin
            s = (f % 8 > 4) ? 0 : f % 8;
            cyc(1'b1, 1'b1, 12'hFFF, f[2:0], f[3]);
            for (int k = 0; k < 40; k++) begin
                r = $random(seed);
                x = r[11:0];
                case (k)
                    0: x = 12'h000;
                    1: x = 12'hFFF >> s;
                    2: x = (12'hFFF >> s) + 12'h001;
                    3: x = 12'h800;
                    4: x = r[11:0] & (12'hFFF >> s);
                    default: x = r[11:0];
                endcase
                cyc(1'b0, r[12] | r[13] | (k < 5), x, r[16:14], r[17]);
            end
        end
        // Mid-run reset returns to 12-bit depth with no shift
        go = 1'b0;
        @(negedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        #1;
        check_reset();
        @(negedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        cur_sh = 3'h0;
        cur_d8 = 1'b0;
        held = 13'h0000;
        cyc(1'b0, 1'b1, 12'hABC, 3'h4, 1'b1);
        cyc(1'b0, 1'b0, 12'h123, 3'h1, 1'b0);
        conclude();
    end
endmodule
